// [hdl/rbc_pkg.sv]
// Shared constants and types for the reset and boot-mode block
package rbc_pkg;

  // Reset timing, in CPU clock cycles
  localparam int unsigned RESET_MIN_LOW_CYCLES     = 8;
  localparam int unsigned RESET_OUT_STRETCH_CYCLES = 1024;

  // Pre-divider field holds divide ratio minus one; reset ratio is six
  localparam int unsigned PREDIV_W     = 3;
  localparam logic [2:0]  PREDIV_RESET = 3'h5;

  // APB register map, byte addresses
  localparam int unsigned ADDR_W      = 8;
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_STATUS = 8'h04;
  localparam logic [7:0]  ADDR_PREDIV = 8'h08;

  // Control register fields
  localparam int unsigned CTRL_SOFT_RESET_BIT = 0;

  // Status register fields
  localparam int unsigned STAT_MODE_LSB  = 0;
  localparam int unsigned STAT_CRYSTAL_BIT = 2;
  localparam int unsigned STAT_PLL_BIT   = 3;
  localparam int unsigned STAT_SRC_LSB   = 4;
  localparam int unsigned STAT_RSVD_BIT  = 6;
  localparam int unsigned STAT_PROG_BIT  = 7;
  localparam int unsigned STAT_SEQ_LSB   = 8;

  typedef enum logic [1:0] {
    SRC_EXT_OSC,
    SRC_RELAX,
    SRC_CRYSTAL
  } rbc_clk_src_type;

  typedef enum logic [1:0] {
    SEQ_RESET,
    SEQ_STRETCH,
    SEQ_RUN
  } rbc_seq_type;

  // Straps captured when reset is released
  typedef struct packed {
    logic [1:0] clock_mode;
    logic       crystal;
    logic       prog_req;
  } rbc_boot_cfg_type;

  // Decoded clock configuration
  typedef struct packed {
    logic            pll_enable;
    rbc_clk_src_type source;
    logic            reserved;
  } rbc_clk_cfg_type;

  localparam rbc_boot_cfg_type BOOT_CFG_RESET = '0;

endpackage

// [hdl/rbc_reset_boot.sv]
// Reset sequencer, boot strap capture and clock-mode decode with APB access
`timescale 1ns/1ps

// What this block does
// - Reset input low eight or more cycles resets CPU and peripherals at once
// - Reset output stays low 1024 cycles after the reset source goes away
// - Low clock-mode pin at 0 makes crystal pin an input sampled for mode
// - Mode 00: PLL off; crystal pin 0 external oscillator, 1 relaxation
// - Mode 01: PLL off, crystal oscillator, crystal pin level ignored
// - Mode 10 with crystal pin 0: PLL on, external oscillator reference
// - Mode 11: PLL on, crystal oscillator reference, crystal pin ignored
// - Reset loads the PLL pre-divider to divide by six
// - Config pin low with test pin low at release enters flash programming
// - Clock output pin toggles on every rising pclk edge, so it runs at half the pclk rate
module rbc_reset_boot #(
  parameter int unsigned STRETCH_CYCLES = rbc_pkg::RESET_OUT_STRETCH_CYCLES,
  parameter int unsigned MIN_LOW        = rbc_pkg::RESET_MIN_LOW_CYCLES
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [rbc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     reset_in_n,
  output logic                          reset_out_n,
  output logic                          cpu_reset_n,
  input  wire logic [1:0]               clock_mode_pins,
  input  wire logic                     crystal_pin_i,
  output logic                          crystal_pin_o,
  output logic                          crystal_pin_oe,
  input  wire logic                     ext_clock_in,
  output logic                          system_clock_output,
  input  wire logic                     reset_config_n,
  input  wire logic                     test_pin,
  output rbc_pkg::rbc_clk_cfg_type      clock_cfg,
  output logic [rbc_pkg::PREDIV_W-1:0]  pll_predivider_field,
  output logic                          flash_prog_mode
);

  localparam int unsigned SW = $clog2(STRETCH_CYCLES + 1);
  localparam logic [SW-1:0] STRETCH_LAST = SW'(STRETCH_CYCLES - 1);

  logic                       pin_reset_q;
  logic                       soft_req_q;
  logic                       src_active;
  rbc_pkg::rbc_seq_type       seq_q;
  logic [SW-1:0]              stretch_q;
  rbc_pkg::rbc_boot_cfg_type  cfg_q;
  rbc_pkg::rbc_clk_cfg_type   clk_d;
  logic [rbc_pkg::PREDIV_W-1:0] prediv_q;
  logic                       access;
  logic                       wr_fire;
  logic                       hit_d;
  logic [31:0]                rdata_d;
  logic                       release_edge;

  rbc_reset_filter #(
    .MIN_LOW (MIN_LOW)
  ) u_filter (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin_n    (reset_in_n),
    .active_q (pin_reset_q)
  );

  assign src_active   = pin_reset_q || soft_req_q;
  assign release_edge = (seq_q == rbc_pkg::SEQ_RESET) && !src_active;

  // Reset sequence; a new source restarts the stretch from zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      seq_q <= rbc_pkg::SEQ_RESET;
    else if (src_active)
      seq_q <= rbc_pkg::SEQ_RESET;
    else
    begin
      case (seq_q)
        rbc_pkg::SEQ_RESET:
          seq_q <= rbc_pkg::SEQ_STRETCH;
        rbc_pkg::SEQ_STRETCH:
          if (stretch_q == STRETCH_LAST)
            seq_q <= rbc_pkg::SEQ_RUN;
        default:
          seq_q <= rbc_pkg::SEQ_RUN;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stretch_q <= '0;
    else if (seq_q != rbc_pkg::SEQ_STRETCH || src_active)
      stretch_q <= '0;
    else if (stretch_q != STRETCH_LAST)
      stretch_q <= stretch_q + SW'(1);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      reset_out_n <= 1'b0;
    else
      reset_out_n <= !src_active && ((seq_q == rbc_pkg::SEQ_RUN) ||
                     (seq_q == rbc_pkg::SEQ_STRETCH && stretch_q == STRETCH_LAST));
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cpu_reset_n <= 1'b0;
    else
      cpu_reset_n <= !src_active && (seq_q != rbc_pkg::SEQ_RESET);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg_q <= rbc_pkg::BOOT_CFG_RESET;
    else if (release_edge)
    begin
      cfg_q.clock_mode <= clock_mode_pins;
      cfg_q.crystal    <= crystal_pin_i;
      cfg_q.prog_req   <= !reset_config_n && !test_pin;
    end
  end

  always_comb
  begin
    clk_d.pll_enable = 1'b0;
    clk_d.source     = rbc_pkg::SRC_RELAX;
    clk_d.reserved   = 1'b0;
    case (cfg_q.clock_mode)
      2'h0:
        clk_d.source = cfg_q.crystal ? rbc_pkg::SRC_RELAX : rbc_pkg::SRC_EXT_OSC;
      2'h1:
        clk_d.source = rbc_pkg::SRC_CRYSTAL;
      2'h2:
        if (!cfg_q.crystal)
        begin
          clk_d.pll_enable = 1'b1;
          clk_d.source     = rbc_pkg::SRC_EXT_OSC;
        end
        else
          // Bad strap: stay on relaxation oscillator without PLL
          clk_d.reserved = 1'b1;
      default:
      begin
        clk_d.pll_enable = 1'b1;
        clk_d.source     = rbc_pkg::SRC_CRYSTAL;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clock_cfg.pll_enable <= 1'b0;
      clock_cfg.source     <= rbc_pkg::SRC_RELAX;
      clock_cfg.reserved   <= 1'b0;
    end
    else
      clock_cfg <= clk_d;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      crystal_pin_oe <= 1'b0;
    else if (seq_q == rbc_pkg::SEQ_RESET)
      crystal_pin_oe <= clock_mode_pins[0];
    else
      crystal_pin_oe <= cfg_q.clock_mode[0];
  end

  // Oscillator amplifier modelled as an inverter of the input clock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      crystal_pin_o <= 1'b0;
    else
      crystal_pin_o <= !ext_clock_in;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      system_clock_output <= 1'b0;
    else
      system_clock_output <= !system_clock_output;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flash_prog_mode <= 1'b0;
    else
      flash_prog_mode <= cfg_q.prog_req;
  end

  // APB slave: one wait state so read data leaves a flip-flop
  assign access  = psel && penable;
  assign wr_fire = access && pready && pwrite;

  always_comb
  begin
    hit_d   = 1'b1;
    rdata_d = 32'h0;
    if (paddr == rbc_pkg::ADDR_CTRL)
      rdata_d = 32'h0;
    else if (paddr == rbc_pkg::ADDR_STATUS)
    begin
      rdata_d[rbc_pkg::STAT_MODE_LSB +: 2] = cfg_q.clock_mode;
      rdata_d[rbc_pkg::STAT_CRYSTAL_BIT]   = cfg_q.crystal;
      rdata_d[rbc_pkg::STAT_PLL_BIT]       = clock_cfg.pll_enable;
      rdata_d[rbc_pkg::STAT_SRC_LSB +: 2]  = clock_cfg.source;
      rdata_d[rbc_pkg::STAT_RSVD_BIT]      = clock_cfg.reserved;
      rdata_d[rbc_pkg::STAT_PROG_BIT]      = flash_prog_mode;
      rdata_d[rbc_pkg::STAT_SEQ_LSB +: 2]  = seq_q;
    end
    else if (paddr == rbc_pkg::ADDR_PREDIV)
      rdata_d[rbc_pkg::PREDIV_W-1:0] = prediv_q;
    else
      hit_d = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= access && !pready;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end
    else if (access && !pready)
    begin
      prdata  <= pwrite ? 32'h0 : rdata_d;
      pslverr <= !hit_d;
    end
  end

  // Software reset request, one cycle wide
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      soft_req_q <= 1'b0;
    else
      soft_req_q <= wr_fire && (paddr == rbc_pkg::ADDR_CTRL) &&
                    pwdata[rbc_pkg::CTRL_SOFT_RESET_BIT];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prediv_q <= rbc_pkg::PREDIV_RESET;
    else if (seq_q == rbc_pkg::SEQ_RESET)
      prediv_q <= rbc_pkg::PREDIV_RESET;
    else if (wr_fire && paddr == rbc_pkg::ADDR_PREDIV)
      prediv_q <= pwdata[rbc_pkg::PREDIV_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pll_predivider_field <= rbc_pkg::PREDIV_RESET;
    else
      pll_predivider_field <= prediv_q;
  end

  // Helper: cycles since the reset source went away
  logic [SW:0] gap_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gap_q <= '0;
    else if (src_active || seq_q == rbc_pkg::SEQ_RESET)
      gap_q <= '0;
    else if (!reset_out_n)
      gap_q <= gap_q + (SW+1)'(1);
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_pin_reset_cpu: assert property (
    (!reset_in_n) [*8] |=> ##1 !cpu_reset_n && !reset_out_n)
    else $error("qualified pin reset did not reset the core");

  a_stretch_length: assert property (
    $rose(reset_out_n) |-> gap_q == (SW+1)'(STRETCH_CYCLES))
    else $error("reset output stretch length wrong");

  a_crystal_input: assert property (
    (seq_q == rbc_pkg::SEQ_RUN && !cfg_q.clock_mode[0]) |=> !crystal_pin_oe)
    else $error("crystal pin driven while used as strap");

  a_mode_00: assert property (
    ($past(presetn) && cfg_q.clock_mode == 2'h0) |=> !clock_cfg.pll_enable &&
      clock_cfg.source == ($past(cfg_q.crystal) ? rbc_pkg::SRC_RELAX : rbc_pkg::SRC_EXT_OSC))
    else $error("mode 00 decoded wrongly");

  a_mode_01: assert property (
    (cfg_q.clock_mode == 2'h1) |=> !clock_cfg.pll_enable &&
      clock_cfg.source == rbc_pkg::SRC_CRYSTAL)
    else $error("mode 01 decoded wrongly");

  a_mode_10: assert property (
    (cfg_q.clock_mode == 2'h2 && !cfg_q.crystal) |=> clock_cfg.pll_enable &&
      clock_cfg.source == rbc_pkg::SRC_EXT_OSC)
    else $error("mode 10 decoded wrongly");

  a_mode_11: assert property (
    (cfg_q.clock_mode == 2'h3) |=> clock_cfg.pll_enable &&
      clock_cfg.source == rbc_pkg::SRC_CRYSTAL)
    else $error("mode 11 decoded wrongly");

  a_prediv_reload: assert property (
    (seq_q == rbc_pkg::SEQ_RESET) |=> ##1 pll_predivider_field == rbc_pkg::PREDIV_RESET)
    else $error("pre-divider not reloaded to divide by six");

  a_prog_entry: assert property (
    release_edge |=> ##1 flash_prog_mode == (!$past(reset_config_n, 2) && !$past(test_pin, 2)))
    else $error("flash programming strap not honoured");

  a_clock_follows: assert property (
    $past(presetn) |=> system_clock_output != $past(system_clock_output))
    else $error("clock output stopped");

  a_strap_hold: assert property (
    !release_edge |=> $stable(cfg_q))
    else $error("straps changed outside reset release");

  c_pll_boot: cover property (release_edge ##2 clock_cfg.pll_enable);
  c_prog_boot: cover property (release_edge ##2 flash_prog_mode);
  c_full_stretch: cover property ($rose(reset_out_n));
  c_soft_reset: cover property (soft_req_q ##1 !cpu_reset_n);

endmodule

// [hdl/rbc_reset_filter.sv]
// Reset pin qualifier: asserts only after the pin has been low long enough
`timescale 1ns/1ps

module rbc_reset_filter #(
  parameter int unsigned MIN_LOW = rbc_pkg::RESET_MIN_LOW_CYCLES
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin_n,
  output logic      active_q
);

  localparam int unsigned CW = $clog2(MIN_LOW + 1);
  localparam logic [CW-1:0] LAST = CW'(MIN_LOW - 1);

  logic [CW-1:0] low_cnt_q;

  // Short glitches on the pin never reach the core
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      low_cnt_q <= '0;
    else if (pin_n)
      low_cnt_q <= '0;
    else if (low_cnt_q != LAST)
      low_cnt_q <= low_cnt_q + CW'(1);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      active_q <= 1'b0;
    else
      active_q <= !pin_n && (low_cnt_q == LAST);
  end

  a_filter_qualifies: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!pin_n) [*8] |=> active_q)
    else $error("reset pin low eight cycles not qualified");

  a_filter_no_glitch: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(active_q) |-> !$past(pin_n, 8) && !$past(pin_n, 1))
    else $error("reset qualified on a short pulse");

endmodule

// [tb/rbc_board_model.sv]
// Board model: reset pin, strap resistors and flash programmer strap
`timescale 1ns/1ps

module rbc_board_model (
  input  wire logic       want_rst_n,
  input  wire logic [1:0] want_mode,
  input  wire logic       want_crystal,
  input  wire logic       want_cfg_n,
  input  wire logic       want_test,
  input  wire logic       crystal_pin_o,
  input  wire logic       crystal_pin_oe,
  output logic            reset_in_n,
  output logic [1:0]      clock_mode_pins,
  output logic            crystal_pin_i,
  output logic            reset_config_n,
  output logic            test_pin
);
  logic strap_crystal;

  assign reset_in_n      = want_rst_n;
  assign clock_mode_pins = want_mode;
  // reserved strap avoided
  // Mode 10 never sees crystal high, so the strap is pulled low there
  assign strap_crystal   = (want_mode == 2'b10) ? 1'b0 : want_crystal;
  // Wire level: device drive wins over the strap resistor
  assign crystal_pin_i   = crystal_pin_oe ? crystal_pin_o : strap_crystal;
  assign reset_config_n  = want_cfg_n;
  assign test_pin        = want_test;
endmodule

// [tb/tb_top.sv]
// Testbench for the reset sequencer and boot strap decode
`timescale 1ns/1ps

module tb_top;
  logic                      pclk = 1'b0;
  logic                      presetn = 1'b0;
  logic                      psel = 1'b0;
  logic                      penable = 1'b0;
  logic                      pwrite = 1'b0;
  logic [7:0]                paddr = 8'h00;
  logic [31:0]               pwdata = 32'h0;
  logic [31:0]               prdata;
  logic                      pready;
  logic                      pslverr;
  logic                      reset_in_n;
  logic                      reset_out_n;
  logic                      cpu_reset_n;
  logic [1:0]                clock_mode_pins;
  logic                      crystal_pin_i;
  logic                      crystal_pin_o;
  logic                      crystal_pin_oe;
  logic                      ext_clock_in = 1'b0;
  logic                      system_clock_output;
  logic                      reset_config_n;
  logic                      test_pin;
  rbc_pkg::rbc_clk_cfg_type  clock_cfg;
  logic [2:0]                pll_predivider_field;
  logic                      flash_prog_mode;
  logic                      want_rst_n = 1'b1;
  logic [1:0]                want_mode = 2'b00;
  logic                      want_crystal = 1'b0;
  logic                      want_cfg_n = 1'b1;
  logic                      want_test = 1'b0;
  int                        failures = 0;
  int                        n_checks = 0;

  always #5 pclk = ~pclk;
  always @(posedge pclk) ext_clock_in <= ~ext_clock_in;

  // Short stretch keeps the run brief
  rbc_reset_boot #(.STRETCH_CYCLES(16), .MIN_LOW(8)) rbc_reset_boot_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_in_n(reset_in_n), .reset_out_n(reset_out_n), .cpu_reset_n(cpu_reset_n),
    .clock_mode_pins(clock_mode_pins), .crystal_pin_i(crystal_pin_i),
    .crystal_pin_o(crystal_pin_o), .crystal_pin_oe(crystal_pin_oe),
    .ext_clock_in(ext_clock_in), .system_clock_output(system_clock_output),
    .reset_config_n(reset_config_n), .test_pin(test_pin), .clock_cfg(clock_cfg),
    .pll_predivider_field(pll_predivider_field), .flash_prog_mode(flash_prog_mode));

  rbc_board_model rbc_board_model_inst (
    .want_rst_n(want_rst_n), .want_mode(want_mode), .want_crystal(want_crystal),
    .want_cfg_n(want_cfg_n), .want_test(want_test), .crystal_pin_o(crystal_pin_o),
    .crystal_pin_oe(crystal_pin_oe), .reset_in_n(reset_in_n),
    .clock_mode_pins(clock_mode_pins), .crystal_pin_i(crystal_pin_i),
    .reset_config_n(reset_config_n), .test_pin(test_pin));

  task automatic print_verdict;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_cfg(input rbc_pkg::rbc_clk_cfg_type got,
                         input rbc_pkg::rbc_clk_cfg_type exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; the slave sets the wait, only the watchdog bounds it
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(rd, exp);
    chk({31'h0, err}, {31'h0, exp_err});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic boot(input logic [1:0] m, input logic x, input logic cn, input logic t);
    want_mode  <= m;
    want_crystal <= x;
    want_cfg_n <= cn;
    want_test  <= t;
    want_rst_n <= 1'b0;
    cyc(10);
    want_rst_n <= 1'b1;
    cyc(25);
  endtask

  function automatic rbc_pkg::rbc_clk_cfg_type exp_cfg(input logic [1:0] m, input logic x);
    exp_cfg.pll_enable = m[1];
    exp_cfg.reserved   = 1'b0;
    if (m[0])
      exp_cfg.source = rbc_pkg::SRC_CRYSTAL;
    else if (!m[1] && x)
      exp_cfg.source = rbc_pkg::SRC_RELAX;
    else
      exp_cfg.source = rbc_pkg::SRC_EXT_OSC;
  endfunction

  initial
  begin
    #200000;
    failures++;
    print_verdict();
  end

  initial
  begin
    int n;
    int lows;
    logic prev;
    cyc(16);
    presetn <= 1'b1;
    cyc(20);
    chk({29'h0, pll_predivider_field}, 32'h5);
    rd_chk(rbc_pkg::ADDR_PREDIV, 32'h5, 1'b0);
    wr(rbc_pkg::ADDR_PREDIV, 32'h3);
    rd_chk(rbc_pkg::ADDR_PREDIV, 32'h3, 1'b0);
    rd_chk(8'h0C, 32'h0, 1'b1);
    // Seven low cycles must be ignored
    want_rst_n <= 1'b0;
    lows = 0;
    for (int i = 0; i < 14; i++)
    begin
      @(posedge pclk);
      if (i == 6)
        want_rst_n <= 1'b1;
      if (cpu_reset_n !== 1'b1)
        lows++;
    end
    chk(lows, 0);
    want_rst_n <= 1'b0;
    cyc(11);
    chk({31'h0, cpu_reset_n}, 32'h0);
    chk({31'h0, reset_out_n}, 32'h0);
    want_rst_n <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (reset_out_n !== 1'b1 && n < 100);
    chk(n, 16 + 3);
    rd_chk(rbc_pkg::ADDR_PREDIV, 32'h5, 1'b0);
    for (int m = 0; m < 4; m++)
      for (int x = 0; x < 2; x++)
        if (!(m == 2 && x == 1))
        begin
          boot(m[1:0], x[0], 1'b1, 1'b0);
          chk_cfg(clock_cfg, exp_cfg(m[1:0], x[0]));
          chk({31'h0, crystal_pin_oe}, {31'h0, m[0]});
          want_mode <= ~m[1:0];
          want_crystal <= ~x[0];
          cyc(3);
          chk_cfg(clock_cfg, exp_cfg(m[1:0], x[0]));
          if (m == 0 && x == 1)
            rd_chk(rbc_pkg::ADDR_STATUS, 32'h214, 1'b0);
        end
    boot(2'b01, 1'b0, 1'b0, 1'b0);
    chk({31'h0, flash_prog_mode}, 32'h1);
    want_cfg_n <= 1'b1;
    cyc(3);
    chk({31'h0, flash_prog_mode}, 32'h1);
    boot(2'b01, 1'b0, 1'b0, 1'b1);
    chk({31'h0, flash_prog_mode}, 32'h0);
    boot(2'b01, 1'b0, 1'b1, 1'b0);
    chk({31'h0, flash_prog_mode}, 32'h0);
    wr(rbc_pkg::ADDR_CTRL, 32'h1);
    @(posedge pclk);
    chk({31'h0, cpu_reset_n}, 32'h0);
    chk({31'h0, reset_out_n}, 32'h0);
    @(posedge pclk);
    prev = system_clock_output;
    repeat (6)
    begin
      @(posedge pclk);
      chk({31'h0, system_clock_output}, {31'h0, ~prev});
      prev = system_clock_output;
    end
    print_verdict();
  end
endmodule
